// [verilog/clrd_port.sv]
// Summary of operation
// - Data write stores the bus byte into the RAM the pointer targets.
// - Text or glyph RAM chosen by the most recent address-set or clear instruction.
// - After each data write the pointer steps by one per entry direction.
// - Data read drives the addressed RAM byte onto the bus.
// - First read without prior address set returns invalid data.
// - Cursor shift loads the read register like a text address set.
// - After each data read the pointer steps by one per entry direction.
// - Read after write returns stale prefetched data; re-set address first.
// - Status read shows busy on bit seven and pointer below.
// - Direction high increments pointer, low decrements it.
// - Two-line text addresses 0x00-0x27 and 0x40-0x67.
// - Instruction 01xxxxxx loads glyph address and selects glyph RAM.
`include "clrd_regs.svh"
module clrd_port (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Host strobe and bus
  input  wire logic       strobe,
  input  wire logic       reg_select_line,
  input  wire logic       read_not_write,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] bus_out,
  output logic            bus_oe,
  // Display side glyph lookup
  input  wire logic [7:0] char_code,
  output logic            char_is_glyph,
  output logic      [2:0] glyph_index,
  // Status
  output logic            busy_indicator,
  output logic            dir_up,
  output logic      [6:0] address_pointer
);
  logic [7:0] text_ram  [0:127];
  logic [7:0] glyph_ram [0:63];
  clrd_pkg::clrd_ram_sel_t sel_q;
  clrd_pkg::clrd_state_t   st_q;
  logic [5:0] cnt_q;
  logic [6:0] ptr_q;
  logic [6:0] ptr_step;
  logic [7:0] prefetch_q;
  logic       dir_q;
  logic       prefetch_req_q;
  logic       data_wr, data_rd, instr_wr, stat_rd;
  logic       is_text_set, is_glyph_set, is_cshift, is_entry, is_clear;

  assign data_wr  = strobe && reg_select_line && !read_not_write;
  assign data_rd  = strobe && reg_select_line && read_not_write;
  assign instr_wr = strobe && !reg_select_line && !read_not_write;
  assign stat_rd  = strobe && !reg_select_line && read_not_write;
  assign is_text_set  = instr_wr && bus_in[7];
  assign is_glyph_set = instr_wr && bus_in[7:6] == 2'b01;
  assign is_cshift    = instr_wr && bus_in[7:4] == 4'h1 && !bus_in[3];
  assign is_entry     = instr_wr && bus_in[7:2] == 6'h01;
  assign is_clear     = instr_wr && bus_in == 8'h01;

  clrd_ptr_step u_step (
    .ptr_in  (ptr_q),
    .up      (is_cshift ? bus_in[2] : dir_q),
    .glyph   (sel_q == clrd_pkg::CLRD_SEL_GLYPH),
    .ptr_out (ptr_step)
  );

  // Pointer and target RAM
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_q <= 7'h00;
      sel_q <= clrd_pkg::CLRD_SEL_TEXT;
    end else if (is_text_set) begin
      ptr_q <= bus_in[6:0];
      sel_q <= clrd_pkg::CLRD_SEL_TEXT;
    end else if (is_glyph_set) begin
      ptr_q <= {1'b0, bus_in[5:0]};
      sel_q <= clrd_pkg::CLRD_SEL_GLYPH;
    end else if (is_clear) begin
      ptr_q <= 7'h00;
      sel_q <= clrd_pkg::CLRD_SEL_TEXT;
    end else if (data_wr || data_rd || (is_cshift && sel_q == clrd_pkg::CLRD_SEL_TEXT)) begin
      ptr_q <= ptr_step;
    end
  end

  // Entry direction
  always_ff @(posedge clk) begin
    if (!reset_n)      dir_q <= 1'b1;
    else if (is_entry) dir_q <= bus_in[1];
    else if (is_clear) dir_q <= 1'b1;
  end

  // RAM writes; no reset on storage
  always_ff @(posedge clk) begin
    if (data_wr) begin
      if (sel_q == clrd_pkg::CLRD_SEL_GLYPH) glyph_ram[ptr_q[5:0]] <= bus_in;
      else                                    text_ram[ptr_q]       <= bus_in;
    end
  end

  // Prefetch: a request is armed by address set or cursor shift, and
  // by each read; the register loads one cycle later from the new pointer.
  // A write does not refresh it, so reads after writes return old data.
  always_ff @(posedge clk) begin
    if (!reset_n) prefetch_req_q <= 1'b0;
    else prefetch_req_q <= is_text_set || is_glyph_set || is_cshift || data_rd;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prefetch_q <= 8'h00;
    end else if (prefetch_req_q) begin
      prefetch_q <= (sel_q == clrd_pkg::CLRD_SEL_GLYPH) ? glyph_ram[ptr_q[5:0]]
                                                        : text_ram[ptr_q];
    end
  end

  // Busy timer after instructions and data accesses
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q  <= clrd_pkg::CLRD_ST_IDLE;
      cnt_q <= 6'h00;
    end else begin
      unique case (st_q)
        clrd_pkg::CLRD_ST_IDLE: begin
          if (instr_wr || data_wr || data_rd) begin
            st_q  <= clrd_pkg::CLRD_ST_BUSY;
            cnt_q <= `CLRD_OP_CYCLES;
          end
        end
        clrd_pkg::CLRD_ST_BUSY: begin
          cnt_q <= cnt_q - 6'h01;
          if (cnt_q == 6'h01) st_q <= clrd_pkg::CLRD_ST_IDLE;
        end
        default: st_q <= clrd_pkg::CLRD_ST_IDLE;
      endcase
    end
  end

  // Read data out, registered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_out <= 8'h00;
      bus_oe  <= 1'b0;
    end else begin
      bus_oe <= data_rd || stat_rd;
      if (stat_rd)
        bus_out <= {st_q == clrd_pkg::CLRD_ST_BUSY, ptr_q};
      else if (data_rd)
        bus_out <= prefetch_q;
    end
  end

  // Glyph lookup for character codes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      char_is_glyph <= 1'b0;
      glyph_index   <= 3'h0;
    end else begin
      char_is_glyph <= char_code[7:4] == 4'h0;
      glyph_index   <= char_code[2:0];
    end
  end

  assign busy_indicator  = st_q == clrd_pkg::CLRD_ST_BUSY;
  assign dir_up          = dir_q;
  assign address_pointer = ptr_q;

  chk_status_busy_bit: assert property (@(posedge clk) disable iff (!reset_n)
    stat_rd |=> bus_out[7] == $past(busy_indicator) && bus_out[6:0] == $past(ptr_q))
    else $error("status byte wrong");
  chk_busy_starts: assert property (@(posedge clk) disable iff (!reset_n)
    (instr_wr || data_wr || data_rd) && !busy_indicator |=> busy_indicator)
    else $error("busy not raised");
  chk_write_steps_up: assert property (@(posedge clk) disable iff (!reset_n)
    data_wr && dir_q && sel_q == clrd_pkg::CLRD_SEL_TEXT && ptr_q != `CLRD_LINE1_LAST
    && ptr_q != `CLRD_LINE2_LAST |=> ptr_q == $past(ptr_q) + 7'h01)
    else $error("write step wrong");
  chk_glyph_step: assert property (@(posedge clk) disable iff (!reset_n)
    data_wr && dir_q && sel_q == clrd_pkg::CLRD_SEL_GLYPH
    |=> ptr_q == {1'b0, $past(ptr_q[5:0]) + 6'h01})
    else $error("glyph step wrong");
  chk_read_steps_down: assert property (@(posedge clk) disable iff (!reset_n)
    data_rd && !dir_q && sel_q == clrd_pkg::CLRD_SEL_TEXT && ptr_q != 7'h00
    && ptr_q != `CLRD_LINE2_BASE |=> ptr_q == $past(ptr_q) - 7'h01)
    else $error("read step wrong");
  chk_line_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    data_wr && dir_q && sel_q == clrd_pkg::CLRD_SEL_TEXT && ptr_q == 7'h27
    |=> ptr_q == 7'h40)
    else $error("line wrap wrong");
  chk_glyph_set: assert property (@(posedge clk) disable iff (!reset_n)
    is_glyph_set |=> sel_q == clrd_pkg::CLRD_SEL_GLYPH && ptr_q == {1'b0, $past(bus_in[5:0])})
    else $error("glyph set wrong");
  chk_text_select: assert property (@(posedge clk) disable iff (!reset_n)
    is_text_set |=> sel_q == clrd_pkg::CLRD_SEL_TEXT)
    else $error("text select wrong");
  chk_cshift_prefetch: assert property (@(posedge clk) disable iff (!reset_n)
    is_cshift && sel_q == clrd_pkg::CLRD_SEL_TEXT |=> prefetch_req_q)
    else $error("shift prefetch missing");
  chk_read_drives_bus: assert property (@(posedge clk) disable iff (!reset_n)
    data_rd |=> bus_oe && bus_out == $past(prefetch_q))
    else $error("read data wrong");
  chk_glyph_map: assert property (@(posedge clk) disable iff (!reset_n)
    char_code == 8'h0B |=> char_is_glyph && glyph_index == 3'h3)
    else $error("glyph map wrong");
endmodule : clrd_port

// [verilog/clrd_regs.svh]
`ifndef CLRD_REGS_SVH
`define CLRD_REGS_SVH
`define CLRD_OP_CYCLES       6'd10
`define CLRD_BUSY_BIT        7
`define CLRD_LINE2_BASE      7'h40
`define CLRD_LINE1_LAST      7'h27
`define CLRD_LINE2_LAST      7'h67
`define CLRD_GLYPH_ADDR_BITS 6
`endif

// [verilog/clrd_pkg.sv]
package clrd_pkg;
  typedef enum logic [1:0] {CLRD_ST_IDLE, CLRD_ST_BUSY} clrd_state_t;
  typedef enum logic {CLRD_SEL_TEXT, CLRD_SEL_GLYPH} clrd_ram_sel_t;
endpackage : clrd_pkg

// [verilog/clrd_ptr_step.sv]
`include "clrd_regs.svh"
module clrd_ptr_step (
  // Pointer in
  input  wire logic [6:0] ptr_in,
  input  wire logic       up,
  input  wire logic       glyph,
  // Stepped pointer
  output logic      [6:0] ptr_out
);
  always_comb begin
    ptr_out = ptr_in;
    if (glyph) begin
      ptr_out = {1'b0, up ? ptr_in[5:0] + 6'h01 : ptr_in[5:0] - 6'h01};
    end else if (up) begin
      // Wrap line 1 end into line 2 and back
      if (ptr_in == `CLRD_LINE1_LAST)      ptr_out = `CLRD_LINE2_BASE;
      else if (ptr_in == `CLRD_LINE2_LAST) ptr_out = 7'h00;
      else                                 ptr_out = ptr_in + 7'h01;
    end else begin
      if (ptr_in == 7'h00)                 ptr_out = `CLRD_LINE2_LAST;
      else if (ptr_in == `CLRD_LINE2_BASE) ptr_out = `CLRD_LINE1_LAST;
      else                                 ptr_out = ptr_in - 7'h01;
    end
  end
endmodule : clrd_ptr_step

// [verification/clrd_host_model.sv]
module clrd_host_model #(parameter int INIT_WAIT = 20) (
  // Clock
  input  wire logic       clk,
  // Host bus
  output logic            strobe,
  output logic            reg_select_line,
  output logic            read_not_write,
  output logic      [7:0] bus_in,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  input  wire logic       busy_indicator,
  // Busy poll bound ran out, or a read saw no bus_oe
  output logic            hung
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q;
  initial begin
    {strobe, reg_select_line, read_not_write, hung} = 4'h0;
    bus_in = 8'h00;
  end
  task xfer(input logic rs, input logic rnw, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    {strobe, reg_select_line, read_not_write, bus_in} <= {1'b1, rs, rnw, d};
    @(posedge clk);
    strobe <= 1'b0;
    bus_in <= ~d; // Released bus must not keep the last byte
    @(posedge clk);
    r = bus_out;
    if (rnw && bus_oe !== 1'b1) hung <= 1'b1;
  endtask : xfer
  task poll;
    int n;
    n = 0;
    while (busy_indicator !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n == 40) hung <= 1'b1;
  endtask : poll
  task cmd(input logic [7:0] d);
    poll();
    xfer(1'b0, 1'b0, d, q);
  endtask : cmd
  task wr(input logic [7:0] d);
    poll();
    xfer(1'b1, 1'b0, d, q);
  endtask : wr
  task rd(output logic [7:0] r);
    poll();
    xfer(1'b1, 1'b1, 8'h00, r);
  endtask : rd
  logic [7:0] seq [5] = '{8'h38, 8'h08, 8'h01, 8'h06, 8'h0C};
  task init;
    repeat (3) begin
      xfer(1'b0, 1'b0, 8'h38, q);
      repeat (INIT_WAIT) @(posedge clk);
    end
    foreach (seq[i]) cmd(seq[i]);
  endtask : init
  task putchar(input logic [2:0] col, input logic line, input logic [7:0] d);
    cmd(8'h80 + {5'h00, col} + (line ? 8'h40 : 8'h00));
    wr(d);
  endtask : putchar
endmodule : clrd_host_model

// [verification/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, reset_n, strobe, reg_select_line, read_not_write, bus_oe;
  logic       char_is_glyph, busy_indicator, dir_up, hung;
  logic [7:0] bus_in, bus_out, char_code, q;
  logic [2:0] glyph_index;
  logic [6:0] address_pointer;
  int         errors = 0;
  int         samples_checked = 0;
  // Rows: column, line, data byte
  logic [2:0] r_col [4] = '{3'h0, 3'h7, 3'h3, 3'h7};
  logic       r_ln  [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0] r_dat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
  logic [7:0] g_in  [4] = '{8'h0B, 8'h08, 8'h20, 8'hF7};
  logic [7:0] g_exp [4] = '{8'h83, 8'h80, 8'h00, 8'h07};
  clrd_port dut_u (
    .clk             (clk),
    .reset_n         (reset_n),
    .strobe          (strobe),
    .reg_select_line (reg_select_line),
    .read_not_write  (read_not_write),
    .bus_in          (bus_in),
    .bus_out         (bus_out),
    .bus_oe          (bus_oe),
    .char_code       (char_code),
    .char_is_glyph   (char_is_glyph),
    .glyph_index     (glyph_index),
    .busy_indicator  (busy_indicator),
    .dir_up          (dir_up),
    .address_pointer (address_pointer)
  );
  clrd_host_model host_u (
    .clk             (clk),
    .strobe          (strobe),
    .reg_select_line (reg_select_line),
    .read_not_write  (read_not_write),
    .bus_in          (bus_in),
    .bus_out         (bus_out),
    .bus_oe          (bus_oe),
    .busy_indicator  (busy_indicator),
    .hung            (hung)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    if (hung === 1'b1) begin
      errors++;
      results();
    end
  end
  initial begin
    reset_n = 1'b0;
    char_code = 8'h00;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    chk({dir_up, address_pointer}, 8'h80);
    chk({bus_oe, busy_indicator, 6'h00}, 8'h00);
    $display("reset test done");
    host_u.init();
    for (int i = 0; i < 4; i++) begin
      host_u.putchar(r_col[i], r_ln[i], r_dat[i]);
      chk({1'b0, address_pointer}, {1'b0, r_ln[i], 3'h0, r_col[i]} + 8'h01);
    end
    for (int i = 0; i < 4; i++) begin
      host_u.cmd({1'b1, r_ln[i], 3'h0, r_col[i]});
      host_u.rd(q);
      chk(q, r_dat[i]);
      chk({1'b0, address_pointer}, {1'b0, r_ln[i], 3'h0, r_col[i]} + 8'h01);
    end
    $display("row test done");
    host_u.cmd(8'hA7);
    host_u.wr(8'h11);
    chk({1'b0, address_pointer}, 8'h40);
    host_u.cmd(8'hE7);
    host_u.wr(8'h12);
    host_u.xfer(1'b0, 1'b1, 8'h00, q);
    chk(q, 8'h80);
    host_u.cmd(8'h04);
    host_u.cmd(8'h85);
    host_u.wr(8'h22);
    chk({dir_up, address_pointer}, 8'h04);
    host_u.cmd(8'h85);
    host_u.rd(q);
    chk({q[7:1], dir_up}, 8'h22);
    chk({1'b0, address_pointer}, 8'h04);
    host_u.cmd(8'h06);
    host_u.cmd(8'h48);
    host_u.wr(8'h1F);
    chk({1'b0, address_pointer}, 8'h09);
    host_u.cmd(8'h48);
    host_u.rd(q);
    chk(q, 8'h1F);
    host_u.cmd(8'hC2);
    host_u.cmd(8'h14);
    host_u.rd(q);
    chk(q, 8'hFF);
    host_u.cmd(8'h80);
    host_u.wr(8'h33);
    host_u.rd(q);
    chk(q, 8'hA5);
    $display("edge test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk({dir_up, address_pointer}, 8'h80);
    host_u.rd(q);
    chk(q, 8'h00);
    $display("second reset test done");
    for (int i = 0; i < 4; i++) begin
      char_code <= g_in[i];
      repeat (3) @(posedge clk);
      chk({char_is_glyph, 4'h0, glyph_index}, g_exp[i]);
    end
    $display("glyph code test done");
    results();
  end
endmodule : tb
